//--- logic/parc_top.sv
`timescale 1ns/1ps
`include "parc_defs.svh"

module parc_top
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Pixel array and column control levels
    input parc_pkg::parc_pix_ctrl_type pix_ctrl,
    input parc_pkg::parc_col_ctrl_type col_ctrl,
    // Readout syncs and step clocks
    input wire logic frame_sync,
    input wire logic row_clk,
    input wire logic line_sync,
    input wire logic pix_clk,
    // Serial configuration port
    input wire logic spi_data,
    input wire logic spi_clk,
    input wire logic spi_latch,
    // Pixel array drive
    output parc_pkg::parc_pix_drv_type pix_drv,
    // Readout position and pixel pairs
    output logic [`PARC_ROW_W-1:0] row_sel,
    output logic [`PARC_COL_W-1:0] col_pair,
    output logic [`PARC_PIX_PER_CLK-1:0] pix_valid,
    // Column controls, active high
    output logic avg_active,
    output logic col_hold,
    output logic col_precharge,
    output logic row_deselect,
    // End-of-scan flags and serial results
    output logic end_of_line,
    output logic end_of_frame,
    output logic spi_echo,
    output logic [`PARC_CFG_W-1:0] cfg_out
);
    // Serial chain results
    logic [`PARC_CFG_W-1:0] cfg;
    logic echo;

    // Scanner links
    logic [`PARC_ROW_W-1:0] row_addr, row_start;
    logic [`PARC_COL_W-1:0] col_addr, col_start;
    logic row_win, col_win, row_eos, col_eos;
    logic line_clk;

    // Pixel drive state
    parc_pkg::parc_pix_drv_type drv_reg, drv_next;
    logic rstp_reg, rstp_next;

    // Scan state
    logic [`PARC_ROW_W-1:0] row_reg, row_next;
    logic [`PARC_COL_W-1:0] col_reg, col_next;
    logic [`PARC_PIX_PER_CLK-1:0] val_reg, val_next;
    logic pclk_reg, pclk_next;
    logic eol_reg, eol_next;
    logic eof_reg, eof_next;

    // Column control state
    logic avg_reg, avg_next;
    logic hold_reg, hold_next;
    logic cpre_reg, cpre_next;
    logic desel_reg, desel_next;

    // Serial result state
    logic echo_reg, echo_next;
    logic [`PARC_CFG_W-1:0] cfgo_reg, cfgo_next;

    // Pick the reset level from the two reset pulses
    function automatic parc_pkg::parc_rst_lvl_type rst_level(input logic full, input logic ds);
        if (full)
            return parc_pkg::PARC_RST_FULL;
        else if (ds)
            return parc_pkg::PARC_RST_DS;
        else
            return parc_pkg::PARC_RST_OFF;
    endfunction : rst_level

    // Configuration chain
    parc_spi u_spi
    (
        .mclk(mclk),
        .resetn(resetn),
        .spi_data(spi_data),
        .spi_clk(spi_clk),
        .spi_latch(spi_latch),
        .cfg(cfg),
        .echo(echo)
    );

    // Row start from configuration, doubled
    assign row_start = {cfg[`PARC_CFG_ROW_LSB +: `PARC_CFG_ROW_W], 1'b0};
    assign col_start = cfg[`PARC_CFG_COL_LSB +: `PARC_CFG_COL_W];
    assign line_clk = pix_clk;

    // Row scanner
    parc_addr #(.W(`PARC_ROW_W), .LAST(`PARC_LAST_ROW)) u_row
    (
        .mclk(mclk),
        .resetn(resetn),
        .sync(frame_sync),
        .step_clk(row_clk),
        .start(row_start),
        .addr(row_addr),
        .windowed(row_win),
        .eos(row_eos)
    );

    // Column scanner, one step per pixel pair
    parc_addr #(.W(`PARC_COL_W), .LAST(`PARC_LAST_COL)) u_col
    (
        .mclk(mclk),
        .resetn(resetn),
        .sync(line_sync),
        .step_clk(line_clk),
        .start(col_start),
        .addr(col_addr),
        .windowed(col_win),
        .eos(col_eos)
    );

    // Rising edge of a pin against its registered copy
    function automatic logic rise(input logic now, input logic prev);
        return now && !prev;
    endfunction : rise

    // Falling edge, the release of a pulse
    function automatic logic fall(input logic now, input logic prev);
        return !now && prev;
    endfunction : fall

    // Pixel drive next values
    always_comb
    begin
        rstp_next = pix_ctrl.reset_pulse;
        // Reset level from the two reset pulses
        drv_next.rst_lvl = rst_level(pix_ctrl.reset_pulse, pix_ctrl.dual_slope_reset);
        // Level copies of the store and boost pulses
        drv_next.precharge_load = !pix_ctrl.precharge_n;
        drv_next.sample_store = !pix_ctrl.sample_n;
        drv_next.vmem_high = pix_ctrl.memory_boost_ctrl;
        // Reset holds the diodes; its release opens integration
        drv_next.integrating = drv_reg.integrating;
        if (pix_ctrl.reset_pulse)
            drv_next.integrating = 1'b0;
        else if (fall(pix_ctrl.reset_pulse, rstp_reg))
            drv_next.integrating = 1'b1;
    end

    // Pixel drive registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            drv_reg <= '{parc_pkg::PARC_RST_OFF, 1'b0, 1'b0, 1'b0, 1'b0};
            rstp_reg <= 1'b0;
        end
        else
        begin
            drv_reg <= drv_next;
            rstp_reg <= rstp_next;
        end
    end

    // Scan position, pixel pairs and end flags
    always_comb
    begin
        // Pixel clock copy for edge detection
        pclk_next = pix_clk;
        // Addresses shown one cycle behind the scanners
        row_next = row_addr;
        col_next = col_addr;
        // Two pixels leave on each pixel clock rise while line sync is low
        if (rise(pix_clk, pclk_reg) && !line_sync)
            val_next = {`PARC_PIX_PER_CLK{1'b1}};
        else
            val_next = '0;
        // End flags only for scans that were not windows
        eol_next = col_eos && !col_win;
        eof_next = row_eos && !row_win;
    end

    // Scan registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            row_reg <= '0;
            col_reg <= '0;
            val_reg <= '0;
            pclk_reg <= 1'b0;
            eol_reg <= 1'b0;
            eof_reg <= 1'b0;
        end
        else
        begin
            row_reg <= row_next;
            col_reg <= col_next;
            val_reg <= val_next;
            pclk_reg <= pclk_next;
            eol_reg <= eol_next;
            eof_reg <= eof_next;
        end
    end

    // Column readout controls, turned active high
    always_comb
    begin
        // Hold and precharge arrive active low
        hold_next = !col_ctrl.column_hold_ctrl_n;
        cpre_next = !col_ctrl.col_precharge_n;
        // Row deselect and averaging are already active high
        desel_next = col_ctrl.row_deselect;
        avg_next = col_ctrl.volt_avg;
    end

    // Column control registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            avg_reg <= 1'b0;
            hold_reg <= 1'b0;
            cpre_reg <= 1'b0;
            desel_reg <= 1'b0;
        end
        else
        begin
            avg_reg <= avg_next;
            hold_reg <= hold_next;
            cpre_reg <= cpre_next;
            desel_reg <= desel_next;
        end
    end

    // Serial echo and configuration copies
    always_comb
    begin
        // Chain tail and latched word, one cycle behind the chain
        echo_next = echo;
        cfgo_next = cfg;
    end

    // Serial result registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            echo_reg <= 1'b0;
            cfgo_reg <= `PARC_CFG_RST;
        end
        else
        begin
            echo_reg <= echo_next;
            cfgo_reg <= cfgo_next;
        end
    end

    // Pixel array drive output
    assign pix_drv = drv_reg;

    // Readout position, pixel pairs and end flags
    assign row_sel = row_reg;
    assign col_pair = col_reg;
    assign pix_valid = val_reg;
    assign end_of_line = eol_reg;
    assign end_of_frame = eof_reg;

    // Column control outputs
    assign avg_active = avg_reg;
    assign col_hold = hold_reg;
    assign col_precharge = cpre_reg;
    assign row_deselect = desel_reg;

    // Serial outputs
    assign spi_echo = echo_reg;
    assign cfg_out = cfgo_reg;
endmodule : parc_top

//--- logic/parc_defs.svh
`ifndef PARC_DEFS_SVH
`define PARC_DEFS_SVH

// Array geometry in pairs of pixels per line and lines per frame
`define PARC_COL_W 10
`define PARC_ROW_W 11
`define PARC_LAST_COL 10'h3FF
`define PARC_LAST_ROW 11'h7FF
// Configuration word layout
`define PARC_CFG_W 24
`define PARC_CFG_ROW_LSB 0
`define PARC_CFG_ROW_W 10
`define PARC_CFG_COL_LSB 10
`define PARC_CFG_COL_W 10
`define PARC_CFG_RST 24'h000000
// Pixel clock and pixel rate, two pixels per cycle
`define PARC_PIXCLK_MHZ 33
`define PARC_PIX_PER_CLK 2
`define PARC_PIXRATE_MHZ (`PARC_PIXCLK_MHZ * `PARC_PIX_PER_CLK)

`endif

//--- logic/parc_pkg.sv
package parc_pkg;
    // Level selection for the pixel reset driver
    typedef enum logic [2:0] {
        PARC_RST_OFF = 3'h1,
        PARC_RST_DS = 3'h2,
        PARC_RST_FULL = 3'h4
    } parc_rst_lvl_type;

    // Pixel array control pulses, in their documented polarity
    typedef struct packed {
        logic reset_pulse;
        logic dual_slope_reset;
        logic precharge_n;
        logic sample_n;
        logic memory_boost_ctrl;
    } parc_pix_ctrl_type;

    // Internal pixel array drive, all active high
    typedef struct packed {
        parc_rst_lvl_type rst_lvl;
        logic precharge_load;
        logic sample_store;
        logic vmem_high;
        logic integrating;
    } parc_pix_drv_type;

    // Column readout controls
    typedef struct packed {
        logic column_hold_ctrl_n;
        logic col_precharge_n;
        logic row_deselect;
        logic volt_avg;
    } parc_col_ctrl_type;
endpackage : parc_pkg

//--- logic/parc_spi.sv
`timescale 1ns/1ps
`include "parc_defs.svh"

// Serial configuration shift chain with parallel latch
module parc_spi
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic spi_data,
    input wire logic spi_clk,
    input wire logic spi_latch,
    output logic [`PARC_CFG_W-1:0] cfg,
    output logic echo
);
    logic [`PARC_CFG_W-1:0] shift_reg, shift_next;
    logic [`PARC_CFG_W-1:0] cfg_reg, cfg_next;
    logic sclk_reg, sclk_next;
    logic latch_reg, latch_next;

    // Shift on serial clock rise, latch on load rise
    always_comb
    begin
        sclk_next = spi_clk;
        latch_next = spi_latch;
        shift_next = shift_reg;
        cfg_next = cfg_reg;
        if (spi_clk && !sclk_reg)
            shift_next = {shift_reg[`PARC_CFG_W-2:0], spi_data};
        if (spi_latch && !latch_reg)
            cfg_next = shift_reg;
    end

    // State registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_reg <= `PARC_CFG_RST;
            cfg_reg <= `PARC_CFG_RST;
            sclk_reg <= 1'b0;
            latch_reg <= 1'b0;
        end
        else
        begin
            shift_reg <= shift_next;
            cfg_reg <= cfg_next;
            sclk_reg <= sclk_next;
            latch_reg <= latch_next;
        end
    end

    assign cfg = cfg_reg;
    assign echo = shift_reg[`PARC_CFG_W-1]; // Chain tail
endmodule : parc_spi

//--- logic/parc_addr.sv
`timescale 1ns/1ps
`include "parc_defs.svh"

// Address counter with sync reload, clock step and end-of-scan flag
module parc_addr
#(
    parameter int W = 10,
    parameter logic [W-1:0] LAST = '1
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sync,
    input wire logic step_clk,
    input wire logic [W-1:0] start,
    output logic [W-1:0] addr,
    output logic windowed,
    output logic eos
);
    logic [W-1:0] addr_reg, addr_next;
    logic clk_reg, clk_next;
    logic win_reg, win_next;
    logic eos_reg, eos_next;
    logic sync_reg, sync_next;

    // Sync dominates; step on rising edge of step clock
    always_comb
    begin
        clk_next = step_clk;
        sync_next = sync;
        addr_next = addr_reg;
        win_next = win_reg;
        eos_next = 1'b0;
        if (sync)
        begin
            addr_next = start;
            // Judged on the first sync cycle only, as sync spans a step clock edge;
            // a nonzero start or a sync that cuts a scan short marks a window
            if (!sync_reg)
                win_next = (start != '0) || (addr_reg != LAST && addr_reg != '0);
        end
        else if (step_clk && !clk_reg)
        begin
            if (addr_reg == LAST)
                eos_next = !win_reg;
            else
                addr_next = addr_reg + 1'b1;
        end
    end

    // State registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            addr_reg <= '0;
            clk_reg <= 1'b0;
            win_reg <= 1'b0;
            eos_reg <= 1'b0;
            sync_reg <= 1'b0;
        end
        else
        begin
            addr_reg <= addr_next;
            clk_reg <= clk_next;
            win_reg <= win_next;
            eos_reg <= eos_next;
            sync_reg <= sync_next;
        end
    end

    assign addr = addr_reg;
    assign windowed = win_reg;
    assign eos = eos_reg;
endmodule : parc_addr

//--- tb/parc_timing_gen.sv
`timescale 1ns/1ps
`include "parc_defs.svh"

// Far-side controller: serial setup and scan clocks
module parc_timing_gen
(
    input wire logic mclk,
    output logic spi_data,
    output logic spi_clk,
    output logic spi_latch,
    output logic row_clk,
    output logic pix_clk
);
    // Idle levels from time zero
    initial
    begin
        {spi_data, spi_clk, spi_latch, row_clk, pix_clk} = 5'h00;
    end

    // Each level stands two cycles
    task automatic wait2;
        repeat (2) @(negedge mclk);
    endtask : wait2

    // Shift a word in, top bit first, data moved only while clock low
    task automatic send(input logic [`PARC_CFG_W-1:0] word);
        for (int i = `PARC_CFG_W - 1; i >= 0; i--)
        begin
            spi_data = word[i];
            wait2();
            spi_clk = 1'h1;
            wait2();
            spi_clk = 1'h0;
            wait2();
        end
        spi_data = ~word[0];
    endtask : send

    // Latch raised only after the whole word is in
    task automatic latch;
        spi_latch = 1'h1;
        wait2();
        wait2();
        spi_latch = 1'h0;
        wait2();
    endtask : latch

    // Row or pixel clock pulses; also the start-up flush
    task automatic pulse(input bit row, input int n);
        repeat (n)
        begin
            if (row)
                row_clk = 1'h1;
            else
                pix_clk = 1'h1;
            wait2();
            row_clk = 1'h0;
            pix_clk = 1'h0;
            wait2();
        end
    endtask : pulse
endmodule : parc_timing_gen

//--- tb/parc_top_chk.sv
`timescale 1ns/1ps
`include "parc_defs.svh"

// Port checks of pixel drive, scanners and serial setup
module parc_top_chk
(
    input wire logic mclk,
    input wire logic resetn,
    input parc_pkg::parc_pix_ctrl_type pix_ctrl,
    input parc_pkg::parc_col_ctrl_type col_ctrl,
    input wire logic frame_sync,
    input wire logic spi_latch,
    input parc_pkg::parc_pix_drv_type pix_drv,
    input logic [`PARC_ROW_W-1:0] row_sel,
    input logic [`PARC_PIX_PER_CLK-1:0] pix_valid,
    input logic avg_active,
    input logic end_of_line,
    input logic end_of_frame,
    input logic [`PARC_CFG_W-1:0] cfg_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // Reset pulse released and kept low
    sequence s_release;
        $fell(pix_ctrl.reset_pulse) ##1 !pix_ctrl.reset_pulse;
    endsequence

    // Pixel driver levels and column averaging
    a_full_wins: assert property (pix_ctrl.reset_pulse |=>
        pix_drv.rst_lvl == parc_pkg::PARC_RST_FULL) else $error("reset level not full");
    a_ds_level: assert property (!pix_ctrl.reset_pulse && pix_ctrl.dual_slope_reset |=>
        pix_drv.rst_lvl == parc_pkg::PARC_RST_DS) else $error("dual slope level wrong");
    a_hold_reset: assert property (pix_ctrl.reset_pulse |=> !pix_drv.integrating)
        else $error("integrating during reset");
    a_integ_start: assert property (s_release |=> pix_drv.integrating)
        else $error("integration not started");
    a_precharge_load: assert property (1'b1 |=>
        pix_drv.precharge_load != $past(pix_ctrl.precharge_n)
        && pix_drv.sample_store != $past(pix_ctrl.sample_n)) else $error("store drive wrong");
    a_vmem_level: assert property (1'b1 |=>
        pix_drv.vmem_high == $past(pix_ctrl.memory_boost_ctrl)) else $error("vmem wrong");
    a_avg_follow: assert property (1'b1 |=> avg_active == $past(col_ctrl.volt_avg))
        else $error("averaging not active");

    // Scan outputs and configuration
    a_pair_out: assert property (pix_valid != 2'h0 |->
        pix_valid == 2'h3 ##1 pix_valid == 2'h0) else $error("pixel pair wrong");
    a_eol_pulse: assert property (end_of_line |=> !end_of_line)
        else $error("line end flag too long");
    a_eof_pulse: assert property (end_of_frame |=> !end_of_frame)
        else $error("frame end flag too long");
    a_cfg_source: assert property ($changed(cfg_out) |->
        $past(spi_latch, 2) || $past(spi_latch, 3)) else $error("config moved unlatched");
    a_row_reload: assert property (frame_sync && cfg_out == $past(cfg_out, 3) |->
        ##2 row_sel == {cfg_out[9:0], 1'h0}) else $error("row start wrong");
endmodule : parc_top_chk

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "parc_defs.svh"

module tb_top;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic frame_sync = 1'h0;
    logic line_sync = 1'h0;
    parc_pkg::parc_pix_ctrl_type pix_ctrl = 5'h06;
    parc_pkg::parc_col_ctrl_type col_ctrl = 4'hC;
    logic spi_data, spi_clk, spi_latch, row_clk, pix_clk;
    parc_pkg::parc_pix_drv_type pix_drv;
    logic [`PARC_ROW_W-1:0] row_sel;
    logic [`PARC_COL_W-1:0] col_pair;
    logic [`PARC_PIX_PER_CLK-1:0] pix_valid;
    logic avg_active, col_hold, col_precharge, row_deselect, end_of_line, end_of_frame;
    logic spi_echo;
    logic [`PARC_CFG_W-1:0] cfg_out;
    int errors = 0;
    int cmp_count = 0;
    int n_eol = 0, n_eof = 0, n_pv = 0, cycles = 0;

    parc_top i_dut (.mclk, .resetn, .pix_ctrl, .col_ctrl, .frame_sync, .row_clk, .line_sync,
        .pix_clk, .spi_data, .spi_clk, .spi_latch, .pix_drv, .row_sel, .col_pair, .pix_valid,
        .avg_active, .col_hold, .col_precharge, .row_deselect, .end_of_line, .end_of_frame,
        .spi_echo, .cfg_out);
    parc_timing_gen i_gen (.mclk, .spi_data, .spi_clk, .spi_latch, .row_clk, .pix_clk);

    // Clock, event counters and hang limit
    always #5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        n_eol += (end_of_line === 1'h1); // Flags only counted, never timing stimulus
        n_eof += (end_of_frame === 1'h1);
        n_pv += (pix_valid === 2'h3);
        if (cycles == 50000)
        begin
            errors++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle

    // Frame or line sync with a clock edge inside it
    task automatic sync_pulse(input bit row);
        frame_sync = row;
        line_sync = !row;
        i_gen.pulse(row, 1);
        frame_sync = 1'h0;
        line_sync = 1'h0;
        idle(3);
    endtask : sync_pulse

    // Flush from reset: one frame end after a full row scan
    task automatic t_flush;
        i_gen.pulse(1, 2048);
        i_gen.pulse(0, 2048);
        check("eof_count", n_eof, 1);
        check("row_last", row_sel, `PARC_LAST_ROW);
        check("pix_pairs", n_pv, 2048);
    endtask : t_flush

    // All four reset input combinations, released last
    task automatic t_reset_lvl;
        for (int i = 3; i >= 0; i--)
        begin
            pix_ctrl.reset_pulse = i[1];
            pix_ctrl.dual_slope_reset = i[0];
            idle(4);
            check("rst_lvl", pix_drv.rst_lvl, i[1] ? 3'h4 : (i[0] ? 3'h2 : 3'h1));
            check("integrating", pix_drv.integrating, !i[1]);
        end
        // Several dual-slope pulses within one integration
        repeat (3)
        begin
            pix_ctrl.dual_slope_reset = 1'h1;
            idle(3);
            check("ds_lvl", pix_drv.rst_lvl, parc_pkg::PARC_RST_DS);
            pix_ctrl.dual_slope_reset = 1'h0;
            idle(3);
            check("ds_integ", pix_drv.integrating, 1'h1);
        end
    endtask : t_reset_lvl

    // Precharge, sample and boost in every pattern
    task automatic t_store;
        for (int i = 0; i < 8; i++)
        begin
            pix_ctrl[2:0] = i[2:0];
            idle(3);
            check("precharge", pix_drv.precharge_load, !i[2]);
            check("sample", pix_drv.sample_store, !i[1]);
            check("vmem", pix_drv.vmem_high, i[0]);
        end
        pix_ctrl[2:0] = 3'h6;
    endtask : t_store

    // Column controls in every pattern
    task automatic t_col;
        for (int i = 0; i < 16; i++)
        begin
            col_ctrl = i[3:0];
            idle(3);
            check("col_hold", col_hold, !i[3]);
            check("col_pre", col_precharge, !i[2]);
            check("deselect", row_deselect, i[1]);
            check("avg", avg_active, i[0]);
        end
        col_ctrl = 4'hC;
    endtask : t_col

    // Latch, echo, then a second word shifted but not latched
    task automatic t_spi;
        i_gen.send(24'h801403);
        i_gen.latch();
        idle(3);
        check("cfg", cfg_out, 24'h801403);
        check("echo", spi_echo, 1'h1);
        i_gen.send(24'h300000);
        idle(3);
        check("cfg_held", cfg_out, 24'h801403);
        check("echo", spi_echo, 1'h0);
    endtask : t_spi

    // Window from row 6 (field 3, doubled) and column 5: no end flags
    task automatic t_window;
        sync_pulse(1);
        check("row_start", row_sel, 11'h006);
        n_eof = 0;
        i_gen.pulse(1, 1);
        check("row_next", row_sel, 11'h007);
        i_gen.pulse(1, 2100);
        check("eof_window", n_eof, 0);
        sync_pulse(0);
        check("col_start", col_pair, 10'h005);
        n_eol = 0;
        i_gen.pulse(0, 1100);
        check("eol_window", n_eol, 0);
    endtask : t_window

    // Full line from column 0: flag only on the step at the end
    task automatic t_full;
        i_gen.latch();
        idle(3);
        sync_pulse(0);
        check("col_zero", col_pair, 10'h000);
        {n_eol, n_pv} = 0;
        i_gen.pulse(0, 1023);
        check("col_last", col_pair, `PARC_LAST_COL);
        check("eol_early", n_eol, 0);
        i_gen.pulse(0, 1);
        check("eol_end", n_eol, 1);
        check("pix_pairs", n_pv, 1024);
        // Early line sync mid-scan makes the next line a window
        sync_pulse(0);
        i_gen.pulse(0, 3);
        sync_pulse(0);
        check("col_restart", col_pair, 10'h000);
        n_eol = 0;
        i_gen.pulse(0, 1024);
        check("eol_partial", n_eol, 0);
    endtask : t_full

    // Main sequence
    initial
    begin
        idle(4);
        resetn = 1'h1;
        t_flush();
        t_reset_lvl();
        t_store();
        t_col();
        t_spi();
        t_window();
        t_full();
        stop_test();
    end
endmodule : tb_top

bind parc_top parc_top_chk i_chk (.mclk, .resetn, .pix_ctrl, .col_ctrl, .frame_sync,
    .spi_latch, .pix_drv, .row_sel, .pix_valid, .avg_active, .end_of_line, .end_of_frame,
    .cfg_out);
